/* dv/tw8_wave_ctrl_tb.sv */
// Self-checking testbench for the timer waveform output block
`timescale 1ns/10ps
module tw8_wave_ctrl_tb;
  import tw8_pkg::*;

  // ************************************************
  // Signals
  // ************************************************
  typedef struct {
    logic [7:0] adr;
    logic [7:0] wd;
    logic [7:0] exp;
  } tw8_row_t;

  logic        clk_i;
  logic        rst_i;
  tw8_wb_req_t wb_r;
  logic        wb_ack_o;
  logic [31:0] wb_dat_o;
  tw8_pin_t    pin_a_o;
  tw8_pin_t    pin_b_o;
  logic        irq_o;
  int          err_total;
  int          comparisons;
  logic [31:0] rd;
  int          hia;
  int          hib;
  int          tga;
  int          tgb;
  int          same;
  tw8_row_t    rows [9] = '{
    '{TW8_OFS_CMPA, 8'h5a, 8'h5a}, '{TW8_OFS_CMPB, 8'ha5, 8'ha5},
    '{TW8_OFS_COUNT, 8'hff, 8'h00}, '{TW8_OFS_PORT, 8'hff, 8'h33},
    '{TW8_OFS_MASK, 8'hff, 8'h07}, '{TW8_OFS_STAT, 8'hff, 8'h00},
    '{8'h20, 8'hff, 8'h00}, '{TW8_OFS_CTRL1, 8'hff, 8'hf3},
    '{TW8_OFS_CTRL2, 8'hff, 8'h09}};

  tw8_wave_ctrl #(.PS_W(16), .PRESCALE(1)) u_dut (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_i     (wb_r),
    .wb_ack_o (wb_ack_o),
    .wb_dat_o (wb_dat_o),
    .pin_a_o  (pin_a_o),
    .pin_b_o  (pin_b_o),
    .irq_o    (irq_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ************************************************
  // Tasks
  // ************************************************
  task automatic finish_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Holds the request until ack is sampled, then idles one cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wb_r <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: {24'h0, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t bus timeout", $time);
      finish_test();
    end
    rd = wb_dat_o;
    wb_r <= '0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 4'h1);
  endtask

  task automatic rdr(input logic [7:0] a);
    wb(1'b0, a, 8'h00, 4'h1);
  endtask

  // Fresh reset per case so counter and wave state start known
  task automatic cfg(input logic [7:0] c1, c2, ca, cb, p, input int settle);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wr(TW8_OFS_PORT, p);
    wr(TW8_OFS_CMPA, ca);
    wr(TW8_OFS_CMPB, cb);
    wr(TW8_OFS_CTRL1, c1);
    wr(TW8_OFS_CTRL2, c2);
    repeat (settle) @(posedge clk_i);
  endtask

  task automatic measure(input int n);
    logic pa;
    logic pb;
    pa = pin_a_o.out;
    pb = pin_b_o.out;
    hia = 0;
    hib = 0;
    tga = 0;
    tgb = 0;
    same = 0;
    repeat (n) begin
      @(posedge clk_i);
      hia += int'(pin_a_o.out === 1'b1);
      hib += int'(pin_b_o.out === 1'b1);
      tga += int'(pin_a_o.out !== pa);
      tgb += int'(pin_b_o.out !== pb);
      same += int'(pin_a_o.out === pin_b_o.out);
      pa = pin_a_o.out;
      pb = pin_b_o.out;
    end
  endtask

  // ************************************************
  // Sequence
  // ************************************************
  initial begin
    err_total = 0;
    comparisons = 0;
    wb_r = '0;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      rdr(rows[i].adr);
      chk(rd, 32'h0);
      wr(rows[i].adr, rows[i].wd);
      rdr(rows[i].adr);
      chk(rd, {24'h0, rows[i].exp});
    end
    // Write without byte lane 0 must be dropped
    wb(1'b1, TW8_OFS_CTRL1, 8'h00, 4'h0);
    rdr(TW8_OFS_CTRL1);
    chk(rd, 32'hf3);
    // Disconnected pins show port data and direction
    cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h13, 3);
    chk({pin_a_o, pin_b_o}, 4'b1101);
    wr(TW8_OFS_PORT, 8'h10);
    chk(pin_a_o, 2'b10);
    // Normal: A set, B toggle on match
    cfg(8'hd0, 8'h01, 8'h05, 8'h05, 8'h03, 50);
    chk({pin_a_o.out, pin_b_o.out}, 2'b11);
    repeat (300) @(posedge clk_i);
    chk({pin_a_o.out, pin_b_o.out}, 2'b10);
    wr(TW8_OFS_CTRL2, 8'h00);
    rdr(TW8_OFS_STAT);
    chk(rd, 32'h07);
    chk(irq_o, 1'b0);
    wr(TW8_OFS_MASK, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1);
    wr(TW8_OFS_STAT, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    rdr(TW8_OFS_STAT);
    chk(rd, 32'h06);
    // Clear on match: TOP from compare A, no overflow at MAX
    cfg(8'hd2, 8'h01, 8'h1f, 8'h08, 8'h03, 40);
    measure(320);
    chk(tgb, 10);
    chk(hia, 320);
    rdr(TW8_OFS_STAT);
    chk(rd, 32'h06);
    // Fast PWM 0xff: A non-inverting, B inverting
    cfg(8'hb3, 8'h01, 8'h80, 8'h80, 8'h03, 300);
    measure(512);
    chk(same, 0);
    chk(32'(hia == 256 || hia == 258), 1);
    // Compare at TOP: steady levels
    cfg(8'ha3, 8'h01, 8'hff, 8'hff, 8'h03, 300);
    measure(512);
    chk(hia, 512);
    chk(hib, 0);
    // Toggle option off without the high bit
    cfg(8'h53, 8'h01, 8'h40, 8'h40, 8'h33, 300);
    measure(512);
    chk(hia, 512);
    // Phase correct 0xff
    cfg(8'hb1, 8'h01, 8'h40, 8'h40, 8'h03, 600);
    measure(1020);
    chk(same, 0);
    chk(32'(hia >= 252 && hia <= 260), 1);
    rdr(TW8_OFS_STAT);
    chk(rd, 32'h07);
    // Fast PWM with TOP from compare A
    cfg(8'h63, 8'h09, 8'h1f, 8'h08, 8'h03, 40);
    measure(320);
    chk(tga, 10);
    chk(32'(hib >= 80 && hib <= 90), 1);
    rdr(TW8_OFS_STAT);
    chk(rd, 32'h07);
    // Phase correct with TOP from compare A
    cfg(8'h61, 8'h09, 8'h1f, 8'h08, 8'h03, 80);
    measure(620);
    chk(tga, 10);
    rdr(TW8_OFS_STAT);
    chk(rd, 32'h07);
    // Reserved mode holds the counter
    cfg(8'hc0, 8'h09, 8'h05, 8'h05, 8'h03, 100);
    rdr(TW8_OFS_COUNT);
    chk(rd, 32'h0);
    chk(pin_a_o.out, 1'b0);
    finish_test();
  end
endmodule

/* hw/tw8_pkg.sv */
// Constants, types and helper functions for the 8-bit timer waveform output block
// Behaviour
// - Nonzero output-mode field routes waveform to pin, except 01 in PWM modes unless channel A with the high mode bit.
// - Non-PWM channel A: off, toggle, clear, set.
// - Non-PWM channel B: off, toggle, clear, set.
// - Fast PWM A: clear/set at match, inverse at BOTTOM.
// - Fast PWM B: 10/11 like A; 01 reserved.
// - Phase PWM A: up/down match actions, toggle option.
// - Phase PWM B: up/down match actions; 01 reserved.
// - Fast PWM A compare at TOP: act at BOTTOM.
// - Phase PWM and fast B at TOP: act at TOP.
// - Control 1 bits 3 and 2 always read zero.
// - Mode is high bit plus two low bits.
// - Mode 0: TOP 0xFF, immediate update, flag at MAX.
// - Mode 1: TOP 0xFF, load at TOP, flag at BOTTOM.
// - Mode 5: TOP from compare A, phase correct.
// - Mode 2: TOP compare A, immediate, flag at MAX.
// - Mode 3: TOP 0xFF, load at BOTTOM, flag MAX.
// - Mode 7: TOP compare A, load BOTTOM, flag TOP.
package tw8_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] TW8_OFS_CTRL1     = 8'h00;
  localparam logic [7:0] TW8_OFS_CTRL2     = 8'h04;
  localparam logic [7:0] TW8_OFS_COUNT     = 8'h08;
  localparam logic [7:0] TW8_OFS_CMPA      = 8'h0c;
  localparam logic [7:0] TW8_OFS_CMPB      = 8'h10;
  localparam logic [7:0] TW8_OFS_STAT      = 8'h14;
  localparam logic [7:0] TW8_OFS_MASK      = 8'h18;
  localparam logic [7:0] TW8_OFS_PORT      = 8'h1c;
  localparam logic [7:0] TW8_CTRL1_WMASK   = 8'hf3;
  localparam logic [7:0] TW8_CTRL2_WMASK   = 8'h09;
  localparam logic [7:0] TW8_PORT_WMASK    = 8'h33;
  localparam logic [7:0] TW8_REG_RST       = 8'h00;
  localparam int         TW8_COMA_LSB      = 6;
  localparam int         TW8_COMB_LSB      = 4;
  localparam int         TW8_WGM_HIGH_BIT  = 3;
  localparam int         TW8_RUN_BIT       = 0;
  localparam int         TW8_DIR_LSB       = 0;
  localparam int         TW8_DAT_LSB       = 4;
  localparam int         TW8_ST_OVF        = 0;
  localparam int         TW8_ST_W          = 3;
  localparam logic [7:0] TW8_MAX           = 8'hff;
  localparam logic [7:0] TW8_BOTTOM        = 8'h00;
  localparam logic [7:0] TW8_ONE           = 8'h01;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    TW8_M_NORMAL   = 3'b000,
    TW8_M_PC_FF    = 3'b001,
    TW8_M_ON_MATCH = 3'b010,
    TW8_M_FAST_FF  = 3'b011,
    TW8_M_RSVD4    = 3'b100,
    TW8_M_PC_OCR   = 3'b101,
    TW8_M_RSVD6    = 3'b110,
    TW8_M_FAST_OCR = 3'b111
  } tw8_mode_t;

  typedef enum logic [1:0] {
    TW8_K_NONPWM = 2'b00,
    TW8_K_FAST   = 2'b01,
    TW8_K_PHASE  = 2'b10,
    TW8_K_RSVD   = 2'b11
  } tw8_kind_t;

  typedef enum logic [1:0] {
    TW8_A_HOLD   = 2'b00,
    TW8_A_TOGGLE = 2'b01,
    TW8_A_CLEAR  = 2'b10,
    TW8_A_SET    = 2'b11
  } tw8_act_t;

  typedef enum logic {
    TW8_D_UP   = 1'b0,
    TW8_D_DOWN = 1'b1
  } tw8_dir_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tw8_wb_req_t;

  typedef struct packed {
    logic out;
    logic oe;
  } tw8_pin_t;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic tw8_kind_t tw8_kind(input tw8_mode_t m);
    tw8_kind_t k;
    k = TW8_K_RSVD;
    unique case (m)
      TW8_M_NORMAL, TW8_M_ON_MATCH:   k = TW8_K_NONPWM;
      TW8_M_FAST_FF, TW8_M_FAST_OCR:  k = TW8_K_FAST;
      TW8_M_PC_FF, TW8_M_PC_OCR:      k = TW8_K_PHASE;
      TW8_M_RSVD4, TW8_M_RSVD6:       k = TW8_K_RSVD;
    endcase
    return k;
  endfunction

  function automatic logic tw8_apply(input logic w, input tw8_act_t a);
    logic r;
    r = w;
    unique case (a)
      TW8_A_HOLD:   r = w;
      TW8_A_TOGGLE: r = ~w;
      TW8_A_CLEAR:  r = 1'b0;
      TW8_A_SET:    r = 1'b1;
    endcase
    return r;
  endfunction

endpackage

/* hw/tw8_wave_ctrl.sv */
// Timer counter, mode decode, compare output logic and Wishbone register slave
`timescale 1ns/10ps
module tw8_wave_ctrl #(
  parameter int PS_W     = 16,
  parameter int PRESCALE = 1
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire tw8_pkg::tw8_wb_req_t wb_i,
  output logic                      wb_ack_o,
  output logic [31:0]               wb_dat_o,
  // Waveform pins
  output tw8_pkg::tw8_pin_t         pin_a_o,
  output tw8_pkg::tw8_pin_t         pin_b_o,
  // Interrupt
  output logic                      irq_o
);
  import tw8_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]          ctrl1_r;
  logic [7:0]          ctrl2_r;
  logic [7:0]          port_r;
  logic [7:0]          cnt_r;
  logic [7:0]          cnt_nxt;
  tw8_dir_t            dir_r;
  tw8_dir_t            dir_nxt;
  logic [7:0]          ocr_buf_r [2];
  logic [7:0]          ocr_act_r [2];
  logic [1:0]          wave_r;
  logic [1:0]          wave_nxt;
  tw8_pin_t            pin_r [2];
  logic [TW8_ST_W-1:0] stat_r;
  logic [TW8_ST_W-1:0] stat_nxt;
  logic [TW8_ST_W-1:0] mask_r;
  logic [PS_W-1:0]     ps_r;
  logic                tick_r;
  logic                ack_r;
  logic [31:0]         dat_r;
  logic                irq_r;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire        acc      = wb_i.cyc & wb_i.stb & ~ack_r;
  wire        wr       = acc & wb_i.we & wb_i.sel[0];
  wire [7:0]  wdat     = wb_i.dat[7:0];
  wire        wr_ctrl1 = wr & (wb_i.adr == TW8_OFS_CTRL1);
  wire        wr_ctrl2 = wr & (wb_i.adr == TW8_OFS_CTRL2);
  wire        wr_cmpa  = wr & (wb_i.adr == TW8_OFS_CMPA);
  wire        wr_cmpb  = wr & (wb_i.adr == TW8_OFS_CMPB);
  wire        wr_stat  = wr & (wb_i.adr == TW8_OFS_STAT);
  wire        wr_mask  = wr & (wb_i.adr == TW8_OFS_MASK);
  wire        wr_port  = wr & (wb_i.adr == TW8_OFS_PORT);
  wire [7:0]  rd8      = (wb_i.adr == TW8_OFS_CTRL1) ? (ctrl1_r & TW8_CTRL1_WMASK) :
                         (wb_i.adr == TW8_OFS_CTRL2) ? ctrl2_r :
                         (wb_i.adr == TW8_OFS_COUNT) ? cnt_r :
                         (wb_i.adr == TW8_OFS_CMPA)  ? ocr_buf_r[0] :
                         (wb_i.adr == TW8_OFS_CMPB)  ? ocr_buf_r[1] :
                         (wb_i.adr == TW8_OFS_STAT)  ? {5'h00, stat_r} :
                         (wb_i.adr == TW8_OFS_MASK)  ? {5'h00, mask_r} :
                         (wb_i.adr == TW8_OFS_PORT)  ? port_r : TW8_BOTTOM;
  wire [31:0] rd_word  = {24'h000000, rd8};

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire        wgm_hi   = ctrl2_r[TW8_WGM_HIGH_BIT];
  wire        run      = ctrl2_r[TW8_RUN_BIT];
  wire tw8_mode_t mode = tw8_mode_t'({wgm_hi, ctrl1_r[1:0]});
  wire tw8_kind_t kind = tw8_kind(mode);
  // Compare A as TOP in modes 2, 5 and 7
  wire        ocr_top  = (mode == TW8_M_ON_MATCH) | (mode == TW8_M_PC_OCR) | (mode == TW8_M_FAST_OCR);
  wire [7:0]  top      = ocr_top ? ocr_act_r[0] : TW8_MAX;
  wire        at_top   = (cnt_r == top);
  wire        at_bot   = (cnt_r == TW8_BOTTOM);
  wire        at_max   = (cnt_r == TW8_MAX);
  wire        fast_wrap = tick_r & (kind == TW8_K_FAST) & at_top;
  wire        pc_top   = tick_r & (kind == TW8_K_PHASE) & at_top & (dir_r == TW8_D_UP);
  wire        pc_bot   = tick_r & (kind == TW8_K_PHASE) & at_bot & (dir_r == TW8_D_DOWN);
  // Double-buffered compare load point per mode class
  wire        ocr_upd  = (kind == TW8_K_NONPWM) | (kind == TW8_K_RSVD) | fast_wrap | pc_top;
  wire        ovf_ev   = ((kind == TW8_K_NONPWM) & tick_r & at_max) |
                         ((mode == TW8_M_FAST_FF) & tick_r & at_max) |
                         ((mode == TW8_M_FAST_OCR) & fast_wrap) |
                         pc_bot;

  // ****************************************************************
  // Counter sequence
  // ****************************************************************
  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    if (tick_r) begin
      unique case (kind)
        TW8_K_NONPWM: cnt_nxt = (mode == TW8_M_ON_MATCH && at_top) ? TW8_BOTTOM : cnt_r + TW8_ONE;
        TW8_K_FAST:   cnt_nxt = at_top ? TW8_BOTTOM : cnt_r + TW8_ONE;
        TW8_K_PHASE: begin
          if (dir_r == TW8_D_UP && at_top) begin
            cnt_nxt = cnt_r - TW8_ONE;
            dir_nxt = TW8_D_DOWN;
          end else if (dir_r == TW8_D_DOWN && at_bot) begin
            cnt_nxt = cnt_r + TW8_ONE;
            dir_nxt = TW8_D_UP;
          end else if (dir_r == TW8_D_UP) begin
            cnt_nxt = cnt_r + TW8_ONE;
          end else begin
            cnt_nxt = cnt_r - TW8_ONE;
          end
        end
        TW8_K_RSVD:   cnt_nxt = cnt_r;
      endcase
    end
  end

  // ****************************************************************
  // Compare output action
  // ****************************************************************
  function automatic tw8_act_t chan_act(input tw8_kind_t k, input logic [1:0] com, input logic match,
                                        input logic wrap, input logic eqtop, input logic is_a,
                                        input logic hi, input tw8_dir_t d, input logic tp);
    tw8_act_t a;
    a = TW8_A_HOLD;
    unique case (k)
      TW8_K_NONPWM: begin
        if (match) begin
          a = tw8_act_t'(com);
        end
      end
      TW8_K_FAST: begin
        if (com == 2'b01) begin
          a = (is_a & hi & match) ? TW8_A_TOGGLE : TW8_A_HOLD;
        end else if (com[1] && eqtop) begin
          if (wrap) begin
            // A acts as at BOTTOM, B as at TOP
            a = is_a ? (com[0] ? TW8_A_CLEAR : TW8_A_SET) : (com[0] ? TW8_A_SET : TW8_A_CLEAR);
          end
        end else if (com[1] && match) begin
          a = com[0] ? TW8_A_SET : TW8_A_CLEAR;
        end else if (com[1] && wrap) begin
          a = com[0] ? TW8_A_CLEAR : TW8_A_SET;
        end
      end
      TW8_K_PHASE: begin
        if (com == 2'b01) begin
          a = (is_a & hi & match) ? TW8_A_TOGGLE : TW8_A_HOLD;
        end else if (com[1] && eqtop) begin
          // Down-count result keeps a full-scale duty steady
          if (tp) begin
            a = com[0] ? TW8_A_CLEAR : TW8_A_SET;
          end
        end else if (com[1] && match) begin
          a = ((d == TW8_D_UP) ^ com[0]) ? TW8_A_CLEAR : TW8_A_SET;
        end
      end
      TW8_K_RSVD: a = TW8_A_HOLD;
    endcase
    return a;
  endfunction

  logic [1:0] com   [2];
  logic [1:0] match;
  logic [1:0] eqtop;
  logic [1:0] conn;
  tw8_act_t   act   [2];

  assign com[0] = ctrl1_r[TW8_COMA_LSB +: 2];
  assign com[1] = ctrl1_r[TW8_COMB_LSB +: 2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      assign match[gi]    = tick_r & (cnt_r == ocr_act_r[gi]);
      assign eqtop[gi]    = (ocr_act_r[gi] == top);
      // In PWM modes, A's toggle code without the high bit, and B's reserved code, leave the pin to the port
      assign conn[gi]     = |com[gi] & ~((com[gi] == 2'b01) & ((kind == TW8_K_FAST) | (kind == TW8_K_PHASE)) &
                                         ~((gi == 0) & wgm_hi));
      assign act[gi]      = chan_act(kind, com[gi], match[gi], fast_wrap, eqtop[gi], (gi == 0), wgm_hi,
                                     dir_r, pc_top);
      assign wave_nxt[gi] = tw8_apply(wave_r[gi], act[gi]);

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ocr_buf_r[gi] <= TW8_REG_RST;
          ocr_act_r[gi] <= TW8_REG_RST;
          wave_r[gi]    <= 1'b0;
          pin_r[gi]     <= '0;
        end else begin
          if ((gi == 0) ? wr_cmpa : wr_cmpb) begin
            ocr_buf_r[gi] <= wdat;
          end
          if (ocr_upd) begin
            ocr_act_r[gi] <= ocr_buf_r[gi];
          end
          wave_r[gi]    <= wave_nxt[gi];
          // Port data drives the pin while the channel is off
          pin_r[gi].out <= conn[gi] ? wave_r[gi] : port_r[TW8_DAT_LSB + gi];
          pin_r[gi].oe  <= port_r[TW8_DIR_LSB + gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Status and interrupt
  // ****************************************************************
  // Hardware set beats a write-one clear in the same cycle
  assign stat_nxt = (stat_r & ~(wr_stat ? wdat[TW8_ST_W-1:0] : 3'h0)) | {match[1], match[0], ovf_ev};

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1_r <= TW8_REG_RST;
      ctrl2_r <= TW8_REG_RST;
      port_r  <= TW8_REG_RST;
      mask_r  <= '0;
      stat_r  <= '0;
      irq_r   <= 1'b0;
      cnt_r   <= TW8_BOTTOM;
      dir_r   <= TW8_D_UP;
      ps_r    <= '0;
      tick_r  <= 1'b0;
      ack_r   <= 1'b0;
      dat_r   <= '0;
    end else begin
      if (wr_ctrl1) ctrl1_r <= wdat & TW8_CTRL1_WMASK;
      if (wr_ctrl2) ctrl2_r <= wdat & TW8_CTRL2_WMASK;
      if (wr_port) port_r <= wdat & TW8_PORT_WMASK;
      if (wr_mask) mask_r <= wdat[TW8_ST_W-1:0];
      stat_r <= stat_nxt;
      irq_r  <= |(stat_r & mask_r);
      cnt_r  <= cnt_nxt;
      dir_r  <= dir_nxt;
      // Timer enable divider; no ticks in reserved modes
      ps_r   <= (ps_r == PS_W'(PRESCALE - 1) || !run) ? '0 : ps_r + 1'b1;
      tick_r <= run & (kind != TW8_K_RSVD) & (ps_r == PS_W'(PRESCALE - 1));
      ack_r  <= acc;
      if (acc) dat_r <= wb_i.we ? 32'h00000000 : rd_word;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign pin_a_o  = pin_r[0];
  assign pin_b_o  = pin_r[1];
  assign irq_o    = irq_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence fast_wrap_s;
    tick_r && kind == TW8_K_FAST && at_top;
  endsequence

  sequence pc_match_s(int ch, tw8_dir_t d);
    kind == TW8_K_PHASE && match[ch] && dir_r == d && !eqtop[ch];
  endsequence

  rsvd_read_zero_a: assert property (acc && !wb_i.we && wb_i.adr == TW8_OFS_CTRL1 |=>
    wb_ack_o && wb_dat_o[3:2] == 2'b00) else $error("reserved control bits read nonzero");
  pin_override_a: assert property (conn[0] |=> pin_a_o.out == $past(wave_r[0]))
    else $error("channel A waveform not on pin");
  pin_dir_a: assert property (port_r[TW8_DIR_LSB + 1] |=> pin_b_o.oe)
    else $error("pin B driver off while direction is output");
  nonpwm_toggle_a: assert property (kind == TW8_K_NONPWM && match[1] && com[1] == 2'b01 |=>
    wave_r[1] != $past(wave_r[1])) else $error("non-PWM toggle on B missing");
  nonpwm_set_a: assert property (kind == TW8_K_NONPWM && match[0] && com[0] == 2'b11 |=>
    wave_r[0]) else $error("non-PWM set on A missing");
  fast_bottom_set_a: assert property (fast_wrap_s and com[0] == 2'b10 |=> wave_r[0])
    else $error("fast PWM A not set at bottom");
  fast_b_rsvd_a: assert property (kind == TW8_K_FAST && com[1] == 2'b01 |=>
    $stable(wave_r[1])) else $error("fast PWM B reserved code changed output");
  phase_up_clear_a: assert property (pc_match_s(0, TW8_D_UP) and com[0] == 2'b10 |=> !wave_r[0])
    else $error("phase PWM A not cleared on up match");
  phase_dn_set_a: assert property (pc_match_s(1, TW8_D_DOWN) and com[1] == 2'b10 |=> wave_r[1])
    else $error("phase PWM B not set on down match");
  fast_a_top_a: assert property (fast_wrap_s and com[0] == 2'b10 && eqtop[0] |=> wave_r[0])
    else $error("fast PWM A compare at TOP not set at bottom");
  fast_b_top_a: assert property (fast_wrap_s and com[1] == 2'b10 && eqtop[1] |=> !wave_r[1])
    else $error("fast PWM B at TOP not cleared");
  normal_ovf_max_a: assert property (tick_r && mode == TW8_M_NORMAL && at_max |=>
    stat_r[TW8_ST_OVF] && cnt_r == TW8_BOTTOM) else $error("normal mode overflow at MAX missing");
  phase_ovf_bot_a: assert property (pc_bot |=> stat_r[TW8_ST_OVF] && dir_r == TW8_D_UP)
    else $error("phase PWM overflow at BOTTOM missing");
  match_clear_top_a: assert property (tick_r && mode == TW8_M_ON_MATCH && at_top |=> cnt_r == TW8_BOTTOM)
    else $error("clear-on-match counter not cleared at TOP");
  fast_buf_hold_a: assert property (kind == TW8_K_FAST && !fast_wrap |=> $stable(ocr_act_r[0]))
    else $error("fast PWM compare loaded outside BOTTOM");
  fast_top_ovf_a: assert property (mode == TW8_M_FAST_OCR && fast_wrap |=> stat_r[TW8_ST_OVF])
    else $error("mode 7 overflow at TOP missing");
  irq_level_a: assert property (|(stat_r & mask_r) |=> irq_o)
    else $error("interrupt not raised for unmasked flag");

endmodule
